// ---- port_pins_defines.vh ----
/*
 * constants for the eight-pin port block: register offsets, field layouts,
 * reset values and drive mode codes.
 * assumes inclusion by bare name from the port design file.
 */
`ifndef PORT_PINS_DEFINES_VH
`define PORT_PINS_DEFINES_VH

// register byte offsets
`define OFS_INT_STATUS 12'h000
`define OFS_INT_MASK 12'h004
`define OFS_EDGE_RISE 12'h008
`define OFS_EDGE_FALL 12'h00c
`define OFS_PORT_CFG 12'h010
`define OFS_IBUF_DIS 12'h014
`define OFS_DATA_OUT 12'h018
`define OFS_DRIVE_MODE 12'h01c
`define OFS_SPECIAL_CFG 12'h020
`define OFS_PIN_STATE 12'h024
`define OFS_RST_CFG 12'h028

// port config fields
`define PCFG_LVTTL_BIT 0
`define PCFG_LOWPWR_BIT 1

// special io config fields
`define SCFG_REG_LO 0
`define SCFG_REG_HI 3
`define SCFG_REF_LO 8
`define SCFG_REF_HI 15

// reference selections per pin pair
`define REF_HALF_IO 2'h0
`define REF_FOUR_TENTHS_IO 2'h1
`define REF_HALF_VREF 2'h2
`define REF_FULL_VREF 2'h3

// drive mode codes
`define DM_HIZ_ANALOG 3'h0
`define DM_HIZ_DIGITAL 3'h1
`define DM_PULL_UP 3'h2
`define DM_PULL_DOWN 3'h3
`define DM_OD_LOW 3'h4
`define DM_OD_HIGH 3'h5
`define DM_STRONG 3'h6
`define DM_PULL_BOTH 3'h7

// reset values
`define RST_DRIVE_MODE 24'h000000
`define RST_BYTE 8'h00
`define RST_WORD 32'h00000000

`endif

// ---- port_pins.v ----
/*
 * eight-pin port: edge interrupt unit, threshold and buffer options,
 * special io level options, drive mode and reset configuration, ahb-lite slave.
 * assumes pins synchronous to REF_CLK and reset configuration word from
 * nonvolatile storage stable at reset release.
 */
//
// Overview of operation
// [RULE1] one interrupt unit per eight-pin port, one request line.
// [RULE2] each pin: rising, falling, both or no edge interrupt.
// [RULE3] configured edge sets status bit and raises the request.
// [RULE4] edge detection and request keep working in low-power modes.
// [RULE5] only edge detection; level interrupts are built elsewhere.
// [RULE6] port-wide choice of cmos or lvttl input thresholds.
// [RULE7] per-pin input buffer disable, independent of drive mode.
// [RULE8] special pin regulated high level; pulls then unavailable.
// [RULE9] special pins paired, each pair shares one reference selection.
// [RULE10] software uses modes 0, 1 or 4 for over-voltage use.
// [RULE11] during reset all pins sit in high-impedance analog.
// [RULE12] at reset release nonvolatile reset config loaded.
// [RULE13] pin drive kept unchanged in low-power modes.
// [RULE14] three-bit drive mode code per pin, codes 0 to 7.
// [RULE15] reading status clears it; request drops when none set.
// [RULE16] pins sampled each clock, compared with previous sample.
`include "port_pins_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module port_pins (
  // clock and reset
  input wire REF_CLK,
  input wire RSTN,
  // ahb-lite slave
  input wire HSEL,
  input wire [11:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output wire HREADYOUT,
  output wire HRESP,
  output reg [31:0] HRDATA,
  // nonvolatile reset configuration, two bits per pin: 0 none, 1 pull-up, 2 pull-down
  input wire [15:0] NV_RST_CFG,
  // pins
  input wire [7:0] PIN_IN,
  output reg [7:0] PIN_OUT,
  output reg [7:0] PIN_OE,
  output reg [7:0] PULL_UP_EN,
  output reg [7:0] PULL_DOWN_EN,
  output reg [7:0] IBUF_EN,
  output reg LVTTL_SEL,
  output reg [3:0] REG_LEVEL_SEL,
  output reg [7:0] PAIR_REF_SEL,
  // interrupt
  output wire IRQ
);

  // ****************************************
  // registers
  // ****************************************
  reg [7:0] status_reg;
  reg [7:0] status_next;
  reg [7:0] mask_reg;
  reg [7:0] rise_en_reg;
  reg [7:0] fall_en_reg;
  reg [1:0] port_cfg_reg;
  reg [7:0] ibuf_dis_reg;
  reg [7:0] data_out_reg;
  reg [23:0] drive_mode_reg;
  reg [11:0] special_cfg_reg;
  reg [15:0] rst_cfg_reg;
  reg [7:0] pin_prev_reg;
  reg [7:0] pin_sample_reg;
  reg [11:0] addr_reg;
  reg write_reg;
  reg read_reg;
  reg [7:0] events;
  integer i;
  // one loop index per process
  integer j;

  localparam ST_LOAD = 2'b01;
  localparam ST_RUN = 2'b10;
  reg [1:0] state_reg;

  function [2:0] mode_of;
    input [23:0] modes;
    input [2:0] idx;
    begin
      mode_of = modes[idx*3 +: 3];
    end
  endfunction

  // ****************************************
  // ahb-lite slave
  // ****************************************
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  wire addr_phase = HSEL & HREADY & HTRANS[1];

  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      addr_reg <= 12'h000;
      write_reg <= 1'b0;
      read_reg <= 1'b0;
    end else begin
      addr_reg <= HADDR;
      write_reg <= addr_phase & HWRITE;
      read_reg <= addr_phase & ~HWRITE;
    end
  end

  // read data registered at the address phase, valid in the data phase
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      HRDATA <= `RST_WORD;
    end else if (addr_phase & ~HWRITE) begin
      case (HADDR)
        `OFS_INT_STATUS: HRDATA <= {24'h000000, status_next};
        `OFS_INT_MASK: HRDATA <= {24'h000000, mask_reg};
        `OFS_EDGE_RISE: HRDATA <= {24'h000000, rise_en_reg};
        `OFS_EDGE_FALL: HRDATA <= {24'h000000, fall_en_reg};
        `OFS_PORT_CFG: HRDATA <= {30'h0, port_cfg_reg};
        `OFS_IBUF_DIS: HRDATA <= {24'h000000, ibuf_dis_reg};
        `OFS_DATA_OUT: HRDATA <= {24'h000000, data_out_reg};
        `OFS_DRIVE_MODE: HRDATA <= {8'h00, drive_mode_reg};
        `OFS_SPECIAL_CFG: HRDATA <= {16'h0000, special_cfg_reg[11:4], 4'h0, special_cfg_reg[3:0]};
        `OFS_PIN_STATE: HRDATA <= {24'h000000, pin_sample_reg};
        `OFS_RST_CFG: HRDATA <= {16'h0000, rst_cfg_reg};
        default: HRDATA <= `RST_WORD;
      endcase
    end
  end

  // ****************************************
  // edge detection and interrupt
  // ****************************************
  always @* begin
    // [RULE2] per-pin edge select
    // [RULE5] edges only, no level mode
    events = (rise_en_reg & pin_sample_reg & ~pin_prev_reg) |
             (fall_en_reg & ~pin_sample_reg & pin_prev_reg);
    status_next = status_reg;
    // [RULE15] read clears status
    if (read_reg && addr_reg == `OFS_INT_STATUS) begin
      status_next = 8'h00;
    end
    // [RULE3] event sets status, wins over clear
    status_next = status_next | events;
  end

  // [RULE16] sample and compare
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_sample_reg <= 8'h00;
      pin_prev_reg <= 8'h00;
      status_reg <= 8'h00;
    end else begin
      pin_sample_reg <= PIN_IN;
      pin_prev_reg <= pin_sample_reg;
      // [RULE4] runs regardless of low-power bit
      status_reg <= status_next;
    end
  end

  // [RULE1] single port request
  assign IRQ = |(status_reg & ~mask_reg);

  // ****************************************
  // configuration registers
  // ****************************************
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mask_reg <= `RST_BYTE;
      rise_en_reg <= `RST_BYTE;
      fall_en_reg <= `RST_BYTE;
      port_cfg_reg <= 2'h0;
      ibuf_dis_reg <= `RST_BYTE;
      data_out_reg <= `RST_BYTE;
      drive_mode_reg <= `RST_DRIVE_MODE;
      special_cfg_reg <= 12'h000;
      rst_cfg_reg <= 16'h0000;
      state_reg <= ST_LOAD;
    end else begin
      case (state_reg)
        // [RULE12] copy nonvolatile reset config after release
        ST_LOAD: begin
          // bus writes landing in this cycle are lost
          rst_cfg_reg <= NV_RST_CFG;
          data_out_reg <= 8'h00;
          for (j = 0; j < 8; j = j + 1) begin
            if (NV_RST_CFG[j*2 +: 2] == 2'h1) begin
              drive_mode_reg[j*3 +: 3] <= `DM_PULL_UP;
              data_out_reg[j] <= 1'b1;
            end else if (NV_RST_CFG[j*2 +: 2] == 2'h2) begin
              drive_mode_reg[j*3 +: 3] <= `DM_PULL_DOWN;
            end
          end
          state_reg <= ST_RUN;
        end
        ST_RUN: begin
          if (write_reg) begin
            case (addr_reg)
              `OFS_INT_MASK: mask_reg <= HWDATA[7:0];
              `OFS_EDGE_RISE: rise_en_reg <= HWDATA[7:0];
              `OFS_EDGE_FALL: fall_en_reg <= HWDATA[7:0];
              `OFS_PORT_CFG: port_cfg_reg <= HWDATA[1:0];
              `OFS_IBUF_DIS: ibuf_dis_reg <= HWDATA[7:0];
              `OFS_DATA_OUT: data_out_reg <= HWDATA[7:0];
              // [RULE14] three bits per pin
              `OFS_DRIVE_MODE: drive_mode_reg <= HWDATA[23:0];
              `OFS_SPECIAL_CFG: special_cfg_reg <=
                {HWDATA[`SCFG_REF_HI:`SCFG_REF_LO], HWDATA[`SCFG_REG_HI:`SCFG_REG_LO]};
              default: mask_reg <= mask_reg;
            endcase
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  // [RULE13] drive follows only registers, untouched by low-power bit
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      // [RULE11] high-impedance analog during reset
      PIN_OUT <= 8'h00;
      PIN_OE <= 8'h00;
      PULL_UP_EN <= 8'h00;
      PULL_DOWN_EN <= 8'h00;
      IBUF_EN <= 8'h00;
      LVTTL_SEL <= 1'b0;
      REG_LEVEL_SEL <= 4'h0;
      PAIR_REF_SEL <= 8'h00;
    end else begin
      // [RULE6] port-wide threshold
      LVTTL_SEL <= port_cfg_reg[`PCFG_LVTTL_BIT];
      // [RULE8] regulated high level per special pin
      REG_LEVEL_SEL <= special_cfg_reg[3:0];
      // [RULE9] one reference per pin pair
      PAIR_REF_SEL <= special_cfg_reg[11:4];
      for (i = 0; i < 8; i = i + 1) begin
        PIN_OUT[i] <= data_out_reg[i];
        case (mode_of(drive_mode_reg, i[2:0]))
          `DM_PULL_UP: begin
            PIN_OE[i] <= ~data_out_reg[i];
            PULL_UP_EN[i] <= data_out_reg[i];
            PULL_DOWN_EN[i] <= 1'b0;
          end
          `DM_PULL_DOWN: begin
            PIN_OE[i] <= data_out_reg[i];
            PULL_UP_EN[i] <= 1'b0;
            PULL_DOWN_EN[i] <= ~data_out_reg[i];
          end
          `DM_OD_LOW: begin
            PIN_OE[i] <= ~data_out_reg[i];
            PULL_UP_EN[i] <= 1'b0;
            PULL_DOWN_EN[i] <= 1'b0;
          end
          `DM_OD_HIGH: begin
            PIN_OE[i] <= data_out_reg[i];
            PULL_UP_EN[i] <= 1'b0;
            PULL_DOWN_EN[i] <= 1'b0;
          end
          `DM_STRONG: begin
            PIN_OE[i] <= 1'b1;
            PULL_UP_EN[i] <= 1'b0;
            PULL_DOWN_EN[i] <= 1'b0;
          end
          `DM_PULL_BOTH: begin
            PIN_OE[i] <= 1'b0;
            PULL_UP_EN[i] <= data_out_reg[i];
            PULL_DOWN_EN[i] <= ~data_out_reg[i];
          end
          default: begin
            PIN_OE[i] <= 1'b0;
            PULL_UP_EN[i] <= 1'b0;
            PULL_DOWN_EN[i] <= 1'b0;
          end
        endcase
        // [RULE8] no pulls on regulated special pins
        if (i < 4 && special_cfg_reg[i]) begin
          PULL_UP_EN[i] <= 1'b0;
          PULL_DOWN_EN[i] <= 1'b0;
        end
        // [RULE7] buffer disable overrides any mode
        IBUF_EN[i] <= ~ibuf_dis_reg[i] &&
                      (mode_of(drive_mode_reg, i[2:0]) != `DM_HIZ_ANALOG);
      end
    end
  end

endmodule // port_pins

`default_nettype wire

// ---- port_pins_monitor.sv ----
/* checker on the port block's ports
   assumes a bind from the bench top file */
`timescale 1ns/100ps
`default_nettype none
module port_pins_monitor (
  // clock and bus
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  // pins and request
  input wire logic [7:0] PIN_IN,
  input wire logic [7:0] PIN_OE,
  input wire logic [7:0] PIN_OUT,
  input wire logic [7:0] PULL_UP_EN,
  input wire logic [7:0] PULL_DOWN_EN,
  input wire logic [7:0] IBUF_EN,
  input wire logic LVTTL_SEL,
  input wire logic [3:0] REG_LEVEL_SEL,
  input wire logic [7:0] PAIR_REF_SEL,
  input wire logic IRQ
);
  wire tk = HSEL && HREADY && HTRANS[1];
  wire wr = tk && HWRITE;
  wire rdap = tk && !HWRITE;
  wire [7:0] pl = PULL_UP_EN | PULL_DOWN_EN;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  chk_reset_park: assert property (disable iff (1'b0)
    !RSTN |-> (PIN_OE | pl | IBUF_EN) == 8'h00) else $error("pin active in reset");
  chk_irq_cause: assert property (
    $rose(IRQ) |-> $past(PIN_IN, 2) != $past(PIN_IN, 3) || $past(wr, 2))
    else $error("request rose without cause");
  chk_irq_drop: assert property (
    $fell(IRQ) |-> $past(tk, 2)) else $error("request fell without access");
  chk_rdata_hold: assert property (
    $changed(HRDATA) |-> $past(rdap)) else $error("read data moved");
  chk_pull_strong: assert property (
    (PIN_OE & pl) == 8'h00) else $error("pull with strong drive");
  chk_reg_nopull: assert property (
    (pl[3:0] & REG_LEVEL_SEL) == 4'h0) else $error("pull in regulated mode");
  chk_drive_hold: assert property (
    $changed({PIN_OE, PIN_OUT, pl, IBUF_EN}) |-> $past(wr, 2) || $past(wr, 3)
    || !$past(RSTN, 2) || !$past(RSTN, 3)) else $error("pin drive moved alone");
  chk_cfg_hold: assert property (
    $changed({LVTTL_SEL, REG_LEVEL_SEL, PAIR_REF_SEL}) |-> $past(wr, 2) || $past(wr, 3))
    else $error("level options moved alone");
endmodule // port_pins_monitor
`default_nettype wire

// ---- pin_world.sv ----
/* outside world of the pins; an undriven pin flips each cycle
   assumes the bench owns ext_en and ext_val */
`timescale 1ns/100ps
`default_nettype none
module pin_world (
  // clock
  input wire logic clk,
  // port drivers
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pu,
  input wire logic [7:0] pd,
  // outside driver and pin level
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  logic [7:0] last = 8'h00;
  always @(posedge clk) last <= pin_in;
  // strong drive, then outside, then pulls, else floating
  assign pin_in = pin_oe & pin_out | ~pin_oe & (ext_en & ext_val | ~ext_en & (pu | ~pd & ~last));
endmodule // pin_world
`default_nettype wire

// ---- port_pins_tb_top.sv ----
/* bench for the port block: bus master, pin world, checks
   assumes checker and pin world compiled first */
`timescale 1ns/100ps
`include "port_pins_defines.vh"
`default_nettype none
module port_pins_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [11:0] haddr = 12'h000;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] lfsr = 32'h8f08f7e7;
  logic [15:0] nv = 16'h0009;
  logic [31:0] rd;
  logic [7:0] ext_en = 8'hff;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] old;
  logic [7:0] ev;
  logic [11:0] ro [4] = '{12'h000, 12'h024, 12'h028, 12'h040};
  wire hready, hresp, irq, lvttl;
  wire [31:0] hrdata;
  wire [7:0] pin_in, pin_out, pin_oe, pu, pd, ibuf, pref;
  wire [3:0] rlev;
  int mismatches = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  port_pins u_port_pins (.REF_CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata), .NV_RST_CFG(nv),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PULL_UP_EN(pu),
    .PULL_DOWN_EN(pd), .IBUF_EN(ibuf), .LVTTL_SEL(lvttl), .REG_LEVEL_SEL(rlev),
    .PAIR_REF_SEL(pref), .IRQ(irq));
  pin_world u_pin_world (.clk(clk), .pin_out, .pin_oe, .pu, .pd, .ext_en, .ext_val, .pin_in);
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] rstv(input logic [11:0] a);
    return a == 12'h018 ? 32'h1 : a == 12'h01c ? 32'h1a : a == 12'h028 ? 32'h9 : 32'h0;
  endfunction
  // {input buffer, strong, pull up, pull down}
  function automatic logic [3:0] dmx(input logic [2:0] m, input logic d);
    return {m != 3'h0, m == 3'h6 || (m == 3'h2 || m == 3'h4) && !d || (m == 3'h3 || m == 3'h5)
      && d, (m == 3'h2 || m == 3'h7) && d, (m == 3'h3 || m == 3'h7) && !d};
  endfunction
  // mask of pins whose nonvolatile reset code equals v
  function automatic logic [7:0] nvpick(input logic [15:0] c, input logic [1:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = c[2*i +: 2] == v;
    end
    return r;
  endfunction
  // drive modes after the load: pull-up code 2, pull-down code 3, others 0
  function automatic logic [31:0] nvmodes(input logic [15:0] c);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 8; i++) begin
      if (c[2*i +: 2] == 2'h1) r[3*i +: 3] = 3'h2;
      if (c[2*i +: 2] == 2'h2) r[3*i +: 3] = 3'h3;
    end
    return r;
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic waitr;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      mismatches++;
      print_verdict;
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    waitr;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitr;
    rd = hrdata;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    chk("park", {pin_oe, pu, pd, ibuf}, 32'h0);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    for (int a = 0; a < 48; a += 4) begin
      bus(1'b0, a[11:0], 32'h0);
      chk("reset value", rd, rstv(a[11:0]));
    end
    chk("reset pulls", {pu[1:0], pd[1:0]}, 32'h6);
    foreach (ro[i]) begin
      bus(1'b1, ro[i], 32'hffffffff);
      bus(1'b0, ro[i], 32'h0);
      chk("read only", rd, rstv(ro[i]));
    end
    for (int k = 0; k < 16; k++) begin
      lfsr = nxt(lfsr);
      bus(1'b1, `OFS_EDGE_RISE, {24'h0, lfsr[7:0]});
      bus(1'b1, `OFS_EDGE_FALL, {24'h0, lfsr[15:8]});
      bus(1'b1, `OFS_PORT_CFG, {30'h0, k > 7, 1'b0});
      bus(1'b0, `OFS_INT_STATUS, 32'h0);
      old = ext_val;
      ext_val <= lfsr[23:16];
      ev = lfsr[23:16] & ~old & lfsr[7:0] | ~lfsr[23:16] & old & lfsr[15:8];
      settle;
      chk("irq", irq, ev != 8'h00);
      bus(1'b0, `OFS_INT_STATUS, 32'h0);
      chk("status", rd, {24'h0, ev});
      bus(1'b0, `OFS_INT_STATUS, 32'h0);
      chk("keep", {hresp, rd[7:0], irq, pin_oe, pu}, 32'h1);
    end
    bus(1'b1, `OFS_EDGE_RISE, 32'hff);
    bus(1'b1, `OFS_EDGE_FALL, 32'hff);
    bus(1'b1, `OFS_INT_MASK, 32'hff);
    ext_val <= ~ext_val;
    settle;
    chk("masked", irq, 32'h0);
    bus(1'b1, `OFS_INT_MASK, 32'h0);
    settle;
    chk("unmasked", irq, 32'h1);
    bus(1'b1, `OFS_INT_MASK, 32'hff);
    ext_en <= 8'hdf;
    for (int m = 0; m < 16; m++) begin
      bus(1'b1, `OFS_DRIVE_MODE, 32'h1a | {14'h0, m[3:1], 15'h0});
      bus(1'b1, `OFS_DATA_OUT, {26'h0, m[0], 5'h01});
      bus(1'b0, `OFS_DRIVE_MODE, 32'h0);
      chk("mode word", rd, 32'h1a | {14'h0, m[3:1], 15'h0});
      settle;
      chk("drive", {ibuf[5], pin_oe[5], pu[5], pd[5]}, dmx(m[3:1], m[0]));
      chk("data out", pin_out, {26'h0, m[0], 5'h01});
    end
    bus(1'b1, `OFS_IBUF_DIS, 32'h20);
    settle;
    chk("ibuf off", {ibuf[5], pu[5]}, 32'h1);
    lfsr = nxt(lfsr);
    bus(1'b1, `OFS_SPECIAL_CFG, {16'h0, lfsr[7:0], 8'h01});
    bus(1'b1, `OFS_PORT_CFG, 32'h1);
    settle;
    chk("special", {rlev, pref, pu[0]}, {19'h0, 4'h1, lfsr[7:0], 1'b0});
    chk("lvttl", lvttl, 32'h1);
    // over-voltage use of the special pins: modes 4, 4, 1 and 0 only
    bus(1'b1, `OFS_DRIVE_MODE, 32'h064);
    bus(1'b1, `OFS_DATA_OUT, 32'h02);
    settle;
    chk("tolerant pins", {pin_oe[3:0], pu[3:0], pd[3:0], ibuf[3:0]}, 32'h1007);
    // second reset in mid-run with a random nonvolatile word
    lfsr = nxt(lfsr);
    @(posedge clk);
    nv <= lfsr[15:0];
    rstn <= 1'b0;
    settle;
    chk("park again", {pin_oe, pu, pd, ibuf}, 32'h0);
    @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b0, `OFS_RST_CFG, 32'h0);
    chk("loaded word", rd, {16'h0, nv});
    bus(1'b0, `OFS_DRIVE_MODE, 32'h0);
    chk("loaded modes", rd, nvmodes(nv));
    bus(1'b0, `OFS_DATA_OUT, 32'h0);
    chk("loaded data", rd, {24'h0, nvpick(nv, 2'h1)});
    chk("loaded pulls", {pu, pd}, {16'h0, nvpick(nv, 2'h1), nvpick(nv, 2'h2)});
    print_verdict;
  end
endmodule // port_pins_tb_top
bind port_pins port_pins_monitor u_port_pins_monitor (.REF_CLK, .RSTN, .HSEL, .HTRANS,
  .HWRITE, .HREADY, .HRDATA, .PIN_IN, .PIN_OE, .PIN_OUT, .PULL_UP_EN, .PULL_DOWN_EN,
  .IBUF_EN, .LVTTL_SEL, .REG_LEVEL_SEL, .PAIR_REF_SEL, .IRQ);
`default_nettype wire
